// *** common/i2cbc_regs.svh ***
// Purpose: Offsets, field positions, resets, timing for the bus control
// Assumes: 8-bit register port, 200 MHz mclk
// Notes:   Definitions only
`ifndef I2CBC_REGS_SVH
`define I2CBC_REGS_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define I2CBC_OFS_CTRL 3'h0
`define I2CBC_OFS_STAT 3'h1
`define I2CBC_OFS_MODE 3'h2
`define I2CBC_OFS_SVA  3'h3
`define I2CBC_OFS_SECOND_OWN_SLAVE_ADDRESS 3'h4

// ----------------------------------------
// Field positions
// ----------------------------------------
`define I2CBC_C_MST  5
`define I2CBC_C_TRS  4
`define I2CBC_C_ACK_CHECK_ENABLE 3
`define I2CBC_C_BUS_BUSY_FLAG 2
`define I2CBC_C_IRQ  1
`define I2CBC_C_SCP  0
`define I2CBC_S_ERROR_STOP_FLAG 7
`define I2CBC_S_STOP 6
`define I2CBC_S_SECOND_ADDR_MATCH_FLAG 5
`define I2CBC_S_AL   4
`define I2CBC_S_AAS  3
`define I2CBC_S_ADZ  2
`define I2CBC_S_ACK_RECEIVED_BIT 1
`define I2CBC_S_TDE  0
`define I2CBC_M_WAIT 0
`define I2CBC_M_ARB_LOST_IRQ_ENABLE 1
`define I2CBC_M_SIM  2

// ----------------------------------------
// Reset values and timing
// ----------------------------------------
`define I2CBC_SVA_RST  7'h7F
`define I2CBC_LAST_BIT 4'h8
`define I2CBC_MCLK_MHZ 200
`define I2CBC_T_COND_NS 5000
`define I2CBC_COND_CYC \
	((`I2CBC_T_COND_NS * `I2CBC_MCLK_MHZ + 999) / 1000)

`endif

// *** common/i2cbc_pkg.sv ***
// Purpose: Types for the bus control block
// Assumes: Nothing
// Notes:   Mode order gives the documented two-bit codes
package i2cbc_pkg;
	typedef enum logic [1:0] {
		MODE_SR, MODE_ST, MODE_MR, MODE_MT
	} i2cbc_mode_e;
	typedef enum logic [2:0] {
		G_IDLE, G_ST1, G_ST2, G_RS1, G_RS2, G_SP1, G_SP2, G_SP3
	} i2cbc_gen_e;
	typedef logic [7:0] i2cbc_byte_t;
endpackage

// *** common/i2cbc_line_if.sv ***
// Purpose: Filtered line levels and events between detector and control
// Assumes: All signals on mclk
// Notes:   Events are one-cycle pulses
`timescale 1ns/1ps
interface i2cbc_line_if;
	logic scl;
	logic sda;
	logic scl_rise;
	logic scl_fall;
	logic start_det;
	logic stop_det;
	modport det (output scl, sda, scl_rise, scl_fall, start_det, stop_det);
	modport ctl (input scl, sda, scl_rise, scl_fall, start_det, stop_det);
endinterface

// *** verilog/i2cbc_sync.sv ***
// Purpose: Three-stage synchroniser with agreement filter for one pin
// Assumes: Idle level high
// Notes:   Level moves only when stages two and three agree
`timescale 1ns/1ps
module i2cbc_sync (
	input  wire logic mclk,
	input  wire logic rst,
	input  wire logic pin,
	output logic      lvl
);
	logic [2:0] sh_ff;
	logic [2:0] nxt_sh;
	logic       lvl_ff;
	logic       nxt_lvl;

	always_comb begin
		nxt_sh  = {sh_ff[1:0], pin};
		nxt_lvl = (sh_ff[1] == sh_ff[2]) ? sh_ff[2] : lvl_ff;
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			sh_ff  <= 3'h7;
			lvl_ff <= 1'b1;
		end else begin
			sh_ff  <= nxt_sh;
			lvl_ff <= nxt_lvl;
		end
	end

	assign lvl = lvl_ff;
endmodule // i2cbc_sync

// *** verilog/i2cbc_cond.sv ***
// Purpose: Edge and start/stop condition detector on filtered lines
// Assumes: Inputs already synchronised
// Notes:   Levels are delayed to line up with the event pulses
`timescale 1ns/1ps
module i2cbc_cond (
	input  wire logic  mclk,
	input  wire logic  rst,
	input  wire logic  scl_lvl,
	input  wire logic  sda_lvl,
	i2cbc_line_if.det  l
);
	logic [1:0] p_ff;
	logic [3:0] ev_ff;
	logic [3:0] nxt_ev;

	always_comb begin
		nxt_ev[0] = scl_lvl & ~p_ff[0];
		nxt_ev[1] = ~scl_lvl & p_ff[0];
		// SCL high before and after, so data edge is a condition
		nxt_ev[2] = p_ff[0] & scl_lvl & p_ff[1] & ~sda_lvl;
		nxt_ev[3] = p_ff[0] & scl_lvl & ~p_ff[1] & sda_lvl;
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			p_ff  <= 2'h3;
			ev_ff <= 4'h0;
		end else begin
			p_ff  <= {sda_lvl, scl_lvl};
			ev_ff <= nxt_ev;
		end
	end

	assign l.scl       = p_ff[0];
	assign l.sda       = p_ff[1];
	assign l.scl_rise  = ev_ff[0];
	assign l.scl_fall  = ev_ff[1];
	assign l.start_det = ev_ff[2];
	assign l.stop_det  = ev_ff[3];
endmodule // i2cbc_cond

// *** verilog/i2cbc_ctrl.sv ***
// Purpose: Two-wire bus condition issue, busy tracking, interrupt flag
// Assumes: Data shifting and SCL stretching live elsewhere
// Notes:   Pins are open drain; outputs only ever pull low
`timescale 1ns/1ps
`include "i2cbc_regs.svh"

// What this block does
// - Master writes busy 0, inhibit 0: stop
// - Master writes busy 1, inhibit 0: start
// - Slave mode ignores software busy writes
// - Start seen on bus sets busy
// - Stop seen on bus clears busy
// - Busy flag readable at any time
// - Inhibit bit resets and reads as one
// - Interrupt flag resets zero, set on events
// - Own start detected sets flag, tx empty
// - Master wait: flag at eighth clock fall
// - Master no wait: flag at ninth rise
// - Lost arbitration: flag after address frame
// - Ack check: received one sets ack, flag
// - Arbitration lost with enable sets flag
// - Slave address match sets flag per byte
// - General call sets call flag, flag
// - Slave stop sets flag when unmasked
// - Flag cleared by read one, write zero
// - Mode bits: slave rx/tx, master rx/tx
module i2cbc_ctrl #(
	parameter int unsigned COND_CYC = `I2CBC_COND_CYC
) (
	input  wire logic              mclk,
	input  wire logic              rst,
	input  wire logic [2:0]        addr,
	input  wire i2cbc_pkg::i2cbc_byte_t wdata,
	input  wire logic              wr,
	input  wire logic              rd,
	output i2cbc_pkg::i2cbc_byte_t rdata,
	input  wire logic              scl_in,
	output logic                   scl_out,
	output logic                   scl_oe,
	input  wire logic              sda_in,
	output logic                   sda_out,
	output logic                   sda_oe,
	output logic                   irq_request_flag
);
	import i2cbc_pkg::*;
	localparam int TW = $clog2(COND_CYC + 1);
	localparam logic [TW-1:0] TLOAD = TW'(COND_CYC - 1);

	logic scl_lvl;
	logic sda_lvl;
	i2cbc_line_if ln ();

	i2cbc_sync u_scl (
		.mclk (mclk),
		.rst  (rst),
		.pin  (scl_in),
		.lvl  (scl_lvl)
	);
	i2cbc_sync u_sda (
		.mclk (mclk),
		.rst  (rst),
		.pin  (sda_in),
		.lvl  (sda_lvl)
	);
	i2cbc_cond u_cond (
		.mclk    (mclk),
		.rst     (rst),
		.scl_lvl (scl_lvl),
		.sda_lvl (sda_lvl),
		.l       (ln.det)
	);

	// ----------------------------------------
	// Decode
	// ----------------------------------------
	logic        wr_ctrl;
	logic        rd_ctrl;
	logic        start_cmd;
	logic        stop_cmd;
	logic        al_now;
	logic        ninth;
	logic        eighth_fall;
	logic        mst_ff;
	logic        trs_ff;
	logic        ack_check_enable_ff;
	logic        bus_busy_flag_ff;
	logic        irq_ff;
	logic        rd1_ff;
	logic [7:0]  st_ff;
	logic [2:0]  md_ff;
	logic [6:0]  sva_ff;
	logic [6:0]  second_own_slave_address_ff;
	logic [3:0]  bit_ff;
	logic        first_ff;
	logic        sess_ff;
	logic [7:0]  sh_ff;
	i2cbc_gen_e  gen_ff;
	logic [TW-1:0] tmr_ff;
	logic        pend_ff;
	logic        hold_ff;
	logic        scl_oe_ff;
	logic        sda_oe_ff;
	i2cbc_mode_e mode;

	assign mode    = i2cbc_mode_e'({mst_ff, trs_ff});
	assign wr_ctrl = wr && (addr == `I2CBC_OFS_CTRL);
	assign rd_ctrl = rd && (addr == `I2CBC_OFS_CTRL);
	assign start_cmd = wr_ctrl && (mode inside {MODE_MR, MODE_MT})
		&& !wdata[`I2CBC_C_SCP] && wdata[`I2CBC_C_BUS_BUSY_FLAG];
	assign stop_cmd = wr_ctrl && (mode inside {MODE_MR, MODE_MT})
		&& !wdata[`I2CBC_C_SCP] && !wdata[`I2CBC_C_BUS_BUSY_FLAG];
	assign ninth = ln.scl_rise && (bit_ff == `I2CBC_LAST_BIT);
	assign eighth_fall = ln.scl_fall && (bit_ff == `I2CBC_LAST_BIT);
	// Another master owns the bus, or SDA held low when we released it
	assign al_now = (start_cmd && bus_busy_flag_ff && !hold_ff)
		|| (gen_ff == G_RS2 && ln.scl && !ln.sda);

	// ----------------------------------------
	// Condition generator
	// ----------------------------------------
	i2cbc_gen_e    nxt_gen;
	logic [TW-1:0] nxt_tmr;
	logic          nxt_pend;
	logic          nxt_hold;

	always_comb begin
		nxt_gen  = gen_ff;
		nxt_tmr  = (tmr_ff != '0) ? tmr_ff - 1'b1 : tmr_ff;
		nxt_pend = pend_ff;
		nxt_hold = hold_ff;
		if (ln.start_det && pend_ff) begin
			nxt_pend = 1'b0;
			nxt_hold = 1'b1;
		end
		if (ln.stop_det)
			nxt_hold = 1'b0;
		if (al_now) begin
			nxt_gen  = G_IDLE;
			nxt_pend = 1'b0;
			nxt_hold = 1'b0;
		end else if (gen_ff == G_IDLE) begin
			if (start_cmd) begin
				// Bus already ours: go via repeated start
				nxt_gen  = hold_ff ? G_RS1 : G_ST1;
				nxt_pend = 1'b1;
				nxt_tmr  = TLOAD;
			end else if (stop_cmd && (hold_ff || bus_busy_flag_ff)) begin
				nxt_gen = G_SP1;
				nxt_tmr = TLOAD;
			end
		end else if (tmr_ff == '0) begin
			unique case (gen_ff)
				G_IDLE: nxt_gen = G_IDLE;
				G_ST1:  nxt_gen = G_ST2;
				G_ST2:  nxt_gen = G_IDLE;
				G_RS1:  nxt_gen = G_RS2;
				G_RS2:  nxt_gen = G_ST1;
				G_SP1:  nxt_gen = G_SP2;
				G_SP2:  nxt_gen = G_SP3;
				G_SP3:  nxt_gen = G_IDLE;
			endcase
			nxt_tmr = TLOAD;
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			gen_ff    <= G_IDLE;
			tmr_ff    <= '0;
			pend_ff   <= 1'b0;
			hold_ff   <= 1'b0;
			scl_oe_ff <= 1'b0;
			sda_oe_ff <= 1'b0;
		end else begin
			gen_ff    <= nxt_gen;
			tmr_ff    <= nxt_tmr;
			pend_ff   <= nxt_pend;
			hold_ff   <= nxt_hold;
			scl_oe_ff <= nxt_gen inside {G_ST2, G_RS1, G_SP1};
			sda_oe_ff <= nxt_gen inside {G_ST1, G_ST2, G_SP1, G_SP2};
		end
	end

	// ----------------------------------------
	// Registers, frame tracking, flags
	// ----------------------------------------
	logic       nxt_mst;
	logic       nxt_trs;
	logic       nxt_ack_check_enable;
	logic       nxt_bus_busy_flag;
	logic       nxt_irq;
	logic       nxt_rd1;
	logic [7:0] nxt_st;
	logic [2:0] nxt_md;
	logic [6:0] nxt_sva;
	logic [6:0] nxt_second_own_slave_address;
	logic [3:0] nxt_bit;
	logic       nxt_first;
	logic       nxt_sess;
	logic [7:0] nxt_sh;
	logic       irq_set;

	always_comb begin
		nxt_mst   = mst_ff;
		nxt_trs   = trs_ff;
		nxt_ack_check_enable  = ack_check_enable_ff;
		nxt_bus_busy_flag  = bus_busy_flag_ff;
		nxt_irq   = irq_ff;
		nxt_rd1   = rd1_ff;
		nxt_st    = st_ff;
		nxt_md    = md_ff;
		nxt_sva   = sva_ff;
		nxt_second_own_slave_address  = second_own_slave_address_ff;
		nxt_bit   = bit_ff;
		nxt_first = first_ff;
		nxt_sess  = sess_ff;
		nxt_sh    = sh_ff;
		irq_set   = 1'b0;
		if (rd_ctrl && irq_ff)
			nxt_rd1 = 1'b1;
		// Busy bit is never taken from wdata
		if (wr_ctrl) begin
			nxt_mst  = wdata[`I2CBC_C_MST];
			nxt_trs  = wdata[`I2CBC_C_TRS];
			nxt_ack_check_enable = wdata[`I2CBC_C_ACK_CHECK_ENABLE];
			nxt_rd1  = 1'b0;
			if (!wdata[`I2CBC_C_IRQ] && rd1_ff)
				nxt_irq = 1'b0;
		end
		if (wr && addr == `I2CBC_OFS_STAT)
			nxt_st = st_ff & wdata;
		if (wr && addr == `I2CBC_OFS_MODE)
			nxt_md = wdata[2:0];
		if (wr && addr == `I2CBC_OFS_SVA)
			nxt_sva = wdata[7:1];
		if (wr && addr == `I2CBC_OFS_SECOND_OWN_SLAVE_ADDRESS)
			nxt_second_own_slave_address = wdata[7:1];
		if (ln.start_det) begin
			nxt_bus_busy_flag  = 1'b1;
			nxt_bit   = 4'h0;
			nxt_first = 1'b1;
			nxt_sess  = 1'b0;
			nxt_st[`I2CBC_S_AAS]  = 1'b0;
			nxt_st[`I2CBC_S_SECOND_ADDR_MATCH_FLAG] = 1'b0;
			nxt_st[`I2CBC_S_ADZ]  = 1'b0;
			if (mst_ff && pend_ff) begin
				nxt_st[`I2CBC_S_TDE] = 1'b1;
				irq_set = 1'b1;
			end
		end
		if (ln.stop_det) begin
			nxt_bus_busy_flag  = 1'b0;
			nxt_first = 1'b0;
			nxt_sess  = 1'b0;
			nxt_st[`I2CBC_S_TDE] = 1'b0;
			if (!mst_ff && sess_ff) begin
				// Stop inside a byte counts as an error stop
				// The stop's own SCL rise counts as one bit
				if (bit_ff > 4'h1)
					nxt_st[`I2CBC_S_ERROR_STOP_FLAG] = 1'b1;
				else
					nxt_st[`I2CBC_S_STOP] = 1'b1;
				if (!md_ff[`I2CBC_M_SIM])
					irq_set = 1'b1;
			end
		end
		if (ln.scl_rise && !ninth) begin
			nxt_sh  = {sh_ff[6:0], ln.sda};
			nxt_bit = bit_ff + 4'h1;
		end
		if (ninth) begin
			nxt_bit   = 4'h0;
			nxt_first = 1'b0;
			if (ack_check_enable_ff && ln.sda && (mst_ff || sess_ff)) begin
				nxt_st[`I2CBC_S_ACK_RECEIVED_BIT] = 1'b1;
				irq_set = 1'b1;
			end
			if (mst_ff && !md_ff[`I2CBC_M_WAIT])
				irq_set = 1'b1;
			if (!mst_ff && sess_ff)
				irq_set = 1'b1;
			if (first_ff && !mst_ff) begin
				if (st_ff[`I2CBC_S_AL])
					irq_set = 1'b1;
				if (sh_ff[7:1] == sva_ff) begin
					nxt_st[`I2CBC_S_AAS] = 1'b1;
					nxt_sess = 1'b1;
					nxt_trs  = sh_ff[0];
					irq_set  = 1'b1;
				end
				if (sh_ff[7:1] == second_own_slave_address_ff) begin
					nxt_st[`I2CBC_S_SECOND_ADDR_MATCH_FLAG] = 1'b1;
					nxt_sess = 1'b1;
					nxt_trs  = sh_ff[0];
					irq_set  = 1'b1;
				end
				if (sh_ff == 8'h00) begin
					nxt_st[`I2CBC_S_ADZ] = 1'b1;
					nxt_sess = 1'b1;
					irq_set  = 1'b1;
				end
			end
		end
		if (eighth_fall && mst_ff && md_ff[`I2CBC_M_WAIT])
			irq_set = 1'b1;
		if (al_now) begin
			nxt_st[`I2CBC_S_AL] = 1'b1;
			nxt_mst = 1'b0;
			nxt_trs = 1'b0;
			if (md_ff[`I2CBC_M_ARB_LOST_IRQ_ENABLE])
				irq_set = 1'b1;
		end
		// Ack value is not reported while checking is off
		if (!nxt_ack_check_enable)
			nxt_st[`I2CBC_S_ACK_RECEIVED_BIT] = 1'b0;
		// Set placed last so an event beats a same-cycle clear
		if (irq_set)
			nxt_irq = 1'b1;
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			mst_ff   <= 1'b0;
			trs_ff   <= 1'b0;
			ack_check_enable_ff  <= 1'b0;
			bus_busy_flag_ff  <= 1'b0;
			irq_ff   <= 1'b0;
			rd1_ff   <= 1'b0;
			st_ff    <= 8'h00;
			md_ff    <= 3'h0;
			sva_ff   <= `I2CBC_SVA_RST;
			second_own_slave_address_ff  <= `I2CBC_SVA_RST;
			bit_ff   <= 4'h0;
			first_ff <= 1'b0;
			sess_ff  <= 1'b0;
			sh_ff    <= 8'hFF;
		end else begin
			mst_ff   <= nxt_mst;
			trs_ff   <= nxt_trs;
			ack_check_enable_ff  <= nxt_ack_check_enable;
			bus_busy_flag_ff  <= nxt_bus_busy_flag;
			irq_ff   <= nxt_irq;
			rd1_ff   <= nxt_rd1;
			st_ff    <= nxt_st;
			md_ff    <= nxt_md;
			sva_ff   <= nxt_sva;
			second_own_slave_address_ff  <= nxt_second_own_slave_address;
			bit_ff   <= nxt_bit;
			first_ff <= nxt_first;
			sess_ff  <= nxt_sess;
			sh_ff    <= nxt_sh;
		end
	end

	// ----------------------------------------
	// Read port
	// ----------------------------------------
	i2cbc_byte_t rdata_ff;
	i2cbc_byte_t nxt_rdata;

	always_comb begin
		nxt_rdata = 8'h00;
		if (rd) begin
			unique case (addr)
				`I2CBC_OFS_CTRL: nxt_rdata = {2'h0, mst_ff, trs_ff,
					ack_check_enable_ff, bus_busy_flag_ff, irq_ff, 1'b1};
				`I2CBC_OFS_STAT: nxt_rdata = st_ff;
				`I2CBC_OFS_MODE: nxt_rdata = {5'h00, md_ff};
				`I2CBC_OFS_SVA:  nxt_rdata = {sva_ff, 1'b0};
				`I2CBC_OFS_SECOND_OWN_SLAVE_ADDRESS: nxt_rdata = {second_own_slave_address_ff, 1'b0};
				default:         nxt_rdata = 8'h00;
			endcase
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst)
			rdata_ff <= 8'h00;
		else
			rdata_ff <= nxt_rdata;
	end

	assign rdata            = rdata_ff;
	assign scl_out          = 1'b0;
	assign sda_out          = 1'b0;
	assign scl_oe           = scl_oe_ff;
	assign sda_oe           = sda_oe_ff;
	assign irq_request_flag = irq_ff;

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);

	sequence s_stop_req;
		stop_cmd && gen_ff == G_IDLE && (hold_ff || bus_busy_flag_ff) && !al_now;
	endsequence
	sequence s_stop_drive;
		gen_ff == G_SP1 && sda_oe_ff && scl_oe_ff;
	endsequence

	stop_issue_a: assert property (s_stop_req |=> s_stop_drive)
		else $error("stop request did not drive stop");
	start_issue_a: assert property (
		(start_cmd && gen_ff == G_IDLE && !al_now) |=>
		(sda_oe_ff && !scl_oe_ff) || (scl_oe_ff && !sda_oe_ff))
		else $error("start request did not drive lines");
	slave_busy_a: assert property (
		(wr_ctrl && !mst_ff && !ln.start_det && !ln.stop_det)
		|=> bus_busy_flag_ff == $past(bus_busy_flag_ff))
		else $error("slave write changed busy");
	busy_set_a: assert property (ln.start_det |=> bus_busy_flag_ff)
		else $error("busy not set on start");
	busy_clr_a: assert property (
		(ln.stop_det && !ln.start_det) |=> !bus_busy_flag_ff)
		else $error("busy not cleared on stop");
	inhibit_read_a: assert property (rd_ctrl |=> rdata[0])
		else $error("inhibit bit read as zero");
	own_start_a: assert property (
		(ln.start_det && mst_ff && pend_ff) |=>
		irq_ff && st_ff[`I2CBC_S_TDE])
		else $error("own start left flag clear");
	nack_flag_a: assert property (
		(ninth && ack_check_enable_ff && ln.sda && mst_ff) |=>
		irq_ff && st_ff[`I2CBC_S_ACK_RECEIVED_BIT])
		else $error("nack did not set flags");
	arb_irq_a: assert property (
		(al_now && md_ff[`I2CBC_M_ARB_LOST_IRQ_ENABLE]) |=>
		irq_ff && st_ff[`I2CBC_S_AL] && !mst_ff)
		else $error("arbitration loss not flagged");
	stop_mask_a: assert property (
		(ln.stop_det && !mst_ff && sess_ff && !md_ff[`I2CBC_M_SIM])
		|=> irq_ff ##1 !sess_ff)
		else $error("slave stop did not set flag");
	irq_keep_a: assert property (
		(irq_ff && wr_ctrl && (wdata[`I2CBC_C_IRQ] || !rd1_ff))
		|=> irq_ff)
		else $error("flag cleared without read-then-zero");
endmodule // i2cbc_ctrl

// *** sim/i2cbc_peer.sv ***
// Purpose: Far-side devices on the two-wire bus, as open-drain pulls
// Assumes: Pull-ups on both lines; SCL half period 32 ns (64 ns link)
// Notes:   SCL stands high between frames; released lines read high
`timescale 1ns/1ps
module i2cbc_peer (
	output logic scl_pull,
	output logic sda_pull
);
	// ----------------------------------------
	// Conditions and bits
	// ----------------------------------------
	localparam time HALF = 32;

	initial begin
		scl_pull = 1'b0;
		sda_pull = 1'b0;
	end

	// SCL goes low first so no SDA move is taken for a stop
	task automatic sda_up();
		scl_pull = 1'b1;
		#(HALF);
		sda_pull = 1'b0;
		#(HALF);
		scl_pull = 1'b0;
		#(HALF);
	endtask

	task automatic start_c();
		sda_up();
		sda_pull = 1'b1;
		#(HALF);
	endtask

	task automatic stop_c();
		scl_pull = 1'b1;
		sda_pull = 1'b1;
		#(HALF);
		scl_pull = 1'b0;
		#(HALF);
		sda_pull = 1'b0;
		#(HALF);
	endtask

	// Sends n bits from v[8] down; SCL left high after the last rise
	task automatic bits(input logic [8:0] v, input int n);
		for (int i = 8; i > 8 - n; i--) begin
			scl_pull = 1'b1;
			#(HALF / 2);
			sda_pull = !v[i];
			#(HALF / 2);
			scl_pull = 1'b0;
			#(HALF);
		end
	endtask

	task automatic fall_c();
		scl_pull = 1'b1;
		#(HALF);
	endtask

	// Holds both lines as the data path would after our start
	task automatic grab();
		scl_pull = 1'b1;
		sda_pull = 1'b1;
	endtask

	task automatic free_c();
		scl_pull = 1'b0;
		sda_pull = 1'b0;
	endtask
endmodule // i2cbc_peer

// *** sim/i2cbc_ctrl_bench.sv ***
// Purpose: Self-checking bench for bus conditions and interrupt flag
// Assumes: COND_CYC shortened to 4; pull-ups on both lines
// Notes:   The peer also clocks bytes the missing data path would send
`timescale 1ns/1ps
`include "i2cbc_regs.svh"
module i2cbc_ctrl_bench;
	import i2cbc_pkg::*;
	// ----------------------------------------
	// Wiring
	// ----------------------------------------
	localparam logic [2:0] O_CT = `I2CBC_OFS_CTRL;
	localparam logic [2:0] O_ST = `I2CBC_OFS_STAT;
	localparam logic [2:0] O_MD = `I2CBC_OFS_MODE;
	localparam logic [2:0] O_SA = `I2CBC_OFS_SVA;
	logic        mclk;
	logic        rst;
	logic [2:0]  addr;
	i2cbc_byte_t wdata;
	logic        wr;
	logic        rd;
	i2cbc_byte_t rdata;
	logic        scl_oe;
	logic        sda_oe;
	logic        scl_o;
	logic        sda_o;
	logic        irq;
	logic        scl_pk;
	logic        sda_pk;
	logic        scl_w;
	logic        sda_w;
	logic [6:0]  sa;
	int          errors;
	int          samples_checked;

	assign scl_w = (scl_oe ? scl_o : 1'b1) && !scl_pk;
	assign sda_w = (sda_oe ? sda_o : 1'b1) && !sda_pk;

	i2cbc_ctrl #(.COND_CYC(4)) u_i2cbc_ctrl (
		.mclk(mclk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr),
		.rd(rd), .rdata(rdata), .scl_in(scl_w), .scl_out(scl_o),
		.scl_oe(scl_oe), .sda_in(sda_w), .sda_out(sda_o),
		.sda_oe(sda_oe),
		.irq_request_flag(irq)
	);
	i2cbc_peer u_i2cbc_peer (.scl_pull(scl_pk), .sda_pull(sda_pk));

	// ----------------------------------------
	// Bus tasks and checks
	// ----------------------------------------
	task automatic wr_reg(input logic [2:0] a, input i2cbc_byte_t v);
		@(posedge mclk);
		addr <= a;
		wdata <= v;
		wr <= 1'b1;
		@(posedge mclk);
		wr <= 1'b0;
	endtask

	task automatic chk(input string n, input i2cbc_byte_t e,
		input i2cbc_byte_t g);
		samples_checked++;
		if (g !== e) begin
			errors++;
			$display("wrong value %s expected %h seen %h", n, e, g);
		end
	endtask

	task automatic chk1(input string n, input logic e, input logic g);
		chk(n, {7'h00, e}, {7'h00, g});
	endtask

	// Read data stand only in the cycle after the strobe
	task automatic rdchk(input string n, input logic [2:0] a,
		input i2cbc_byte_t e, input i2cbc_byte_t m);
		@(posedge mclk);
		addr <= a;
		rd <= 1'b1;
		@(posedge mclk);
		rd <= 1'b0;
		@(negedge mclk);
		chk(n, e & m, rdata & m);
	endtask

	// Clearing needs a read of the flag first, then the write
	task automatic clr(input i2cbc_byte_t v);
		rdchk("irq armed", O_CT, 8'h02, 8'h02);
		wr_reg(O_CT, v);
	endtask

	task automatic settle();
		repeat (12) @(negedge mclk);
	endtask

	task automatic wait_irq();
		int k;
		for (k = 0; k < 60 && irq !== 1'b1; k++)
			@(negedge mclk);
		chk1("irq", 1'b1, irq);
		if (k == 60)
			conclude();
	endtask

	task automatic wait_oe(input logic c, input logic s);
		int k;
		for (k = 0; k < 30 && {scl_oe, sda_oe} !== {c, s}; k++)
			@(negedge mclk);
		chk("pulls", {6'h00, c, s}, {6'h00, scl_oe, sda_oe});
		if (k == 30)
			conclude();
	endtask

	task automatic conclude();
		$display("errors %0d samples_checked %0d", errors, samples_checked);
		if (errors == 0 && samples_checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// ----------------------------------------
	// Sequence
	// ----------------------------------------
	initial begin
		mclk = 1'b0;
		forever #2.5 mclk = !mclk;
	end

	initial begin
		rst = 1'b1;
		addr = 3'h0;
		wdata = 8'h00;
		wr = 1'b0;
		rd = 1'b0;
		errors = 0;
		samples_checked = 0;
		void'($urandom(32'h66C6));
		// Avoids zero and a clash with the second address reset value
		sa = 7'($urandom_range(125, 2));
		repeat (6) @(posedge mclk);
		rst <= 1'b0;
		rdchk("ctrl", O_CT, 8'h01, 8'hFF);
		chk1("irq", 1'b0, irq);
		rdchk("status", O_ST, 8'h00, 8'hFF);
		rdchk("own addr", O_SA, 8'hFE, 8'hFF);
		rdchk("unmapped", 3'h5, 8'h00, 8'hFF);
		for (int m = 0; m < 4; m++) begin
			wr_reg(O_CT, {2'b00, 2'(m), 4'h0});
			rdchk("mode", O_CT, {2'b00, 2'(m), 4'h1}, 8'hFF);
		end
		wr_reg(O_CT, 8'h05);
		wr_reg(O_CT, 8'h04);
		rdchk("slave busy", O_CT, 8'h01, 8'hFF);
		chk1("sda pull", 1'b0, sda_oe);
		wr_reg(O_SA, {sa, 1'b0});
		u_i2cbc_peer.start_c();
		settle();
		rdchk("busy", O_CT, 8'h05, 8'hFF);
		u_i2cbc_peer.bits({sa, 1'b0, 1'b1}, 9);
		wait_irq();
		rdchk("match", O_ST, 8'h08, 8'h0E);
		wr_reg(O_CT, 8'h01);
		settle();
		chk1("irq", 1'b1, irq);
		clr(8'h03);
		settle();
		chk1("irq", 1'b1, irq);
		clr(8'h01);
		settle();
		chk1("irq", 1'b0, irq);
		u_i2cbc_peer.bits({8'($urandom), 1'b1}, 9);
		wait_irq();
		clr(8'h01);
		u_i2cbc_peer.stop_c();
		wait_irq();
		rdchk("stop", O_ST, 8'h40, 8'h40);
		rdchk("free", O_CT, 8'h03, 8'hFF);
		clr(8'h01);
		wr_reg(O_MD, 8'h04);
		u_i2cbc_peer.start_c();
		u_i2cbc_peer.bits({sa ^ 7'h01, 1'b0, 1'b1}, 9);
		settle();
		chk1("irq", 1'b0, irq);
		u_i2cbc_peer.start_c();
		u_i2cbc_peer.bits({7'h00, 1'b0, 1'b1}, 9);
		wait_irq();
		rdchk("call", O_ST, 8'h04, 8'h04);
		clr(8'h01);
		u_i2cbc_peer.stop_c();
		settle();
		chk1("irq", 1'b0, irq);
		wr_reg(O_MD, 8'h00);
		wr_reg(O_CT, 8'h39);
		wr_reg(O_CT, 8'h3C);
		@(negedge mclk);
		chk1("sda pull", 1'b1, sda_oe);
		chk1("scl pull", 1'b0, scl_oe);
		wait_oe(1'b1, 1'b1);
		u_i2cbc_peer.grab();
		wait_oe(1'b0, 1'b0);
		wait_irq();
		rdchk("started", O_CT, 8'h3F, 8'hFF);
		rdchk("tx empty", O_ST, 8'h01, 8'h01);
		clr(8'h39);
		u_i2cbc_peer.bits({8'($urandom), 1'b1}, 9);
		wait_irq();
		rdchk("ack in", O_ST, 8'h02, 8'h02);
		clr(8'h39);
		wr_reg(O_MD, 8'h01);
		u_i2cbc_peer.bits({8'($urandom), 1'b0}, 8);
		settle();
		chk1("irq", 1'b0, irq);
		u_i2cbc_peer.fall_c();
		wait_irq();
		clr(8'h39);
		u_i2cbc_peer.bits(9'h000, 1);
		settle();
		chk1("irq", 1'b0, irq);
		wr_reg(O_ST, 8'hFE);
		u_i2cbc_peer.sda_up();
		wr_reg(O_CT, 8'h3C);
		@(negedge mclk);
		chk("restart pulls", 8'h02, {6'h00, scl_oe, sda_oe});
		wait_oe(1'b1, 1'b1);
		u_i2cbc_peer.grab();
		wait_oe(1'b0, 1'b0);
		wait_irq();
		rdchk("restarted", O_ST, 8'h01, 8'h01);
		clr(8'h39);
		wr_reg(O_CT, 8'h38);
		@(negedge mclk);
		chk("stop pulls", 8'h03, {6'h00, scl_oe, sda_oe});
		chk("drive level", 8'h00, {6'h00, scl_o, sda_o});
		u_i2cbc_peer.free_c();
		wait_oe(1'b0, 1'b0);
		settle();
		rdchk("stopped", O_CT, 8'h39, 8'hFF);
		wr_reg(O_MD, 8'h02);
		u_i2cbc_peer.start_c();
		settle();
		wr_reg(O_CT, 8'h3C);
		@(negedge mclk);
		chk1("sda pull", 1'b0, sda_oe);
		wait_irq();
		rdchk("lost", O_CT, 8'h0F, 8'hFF);
		rdchk("lost flag", O_ST, 8'h10, 8'h10);
		clr(8'h09);
		u_i2cbc_peer.bits({sa ^ 7'h01, 1'b0, 1'b1}, 9);
		wait_irq();
		clr(8'h09);
		u_i2cbc_peer.stop_c();
		settle();
		rdchk("end", O_CT, 8'h09, 8'hFF);
		conclude();
	end
endmodule // i2cbc_ctrl_bench
